// >>> vie_ctrl.sv
// Vectored interrupt controller with edge select, priority and AHB-Lite registers
// Behaviour
// - Software-set priority encoder picks pending request
// - Machine cycle disables interrupts, saves PC, flags
// - Vector bytes at 2n, 2n+1 form address
// - Requests recorded while masked; software polls them
// - Comparator one to line 2, two to 0
// - Lines 2 and 0: rising, falling or both
// - Edge code in bits 7:6 of register 250
// - Software reads external interrupt pin levels
// - Line 1 falling-edge pin, vector 2 and 3
// - Line 0 pin; lines 3-5 timers, detector
//
// Design decision made here: the AHB-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module vie_ctrl
	import vie_pkg::*;
#(
	parameter int ADDR_W = 16
)(
	// Clock, reset, clock enable
	input  wire logic              hclk,
	input  wire logic              hresetn,
	input  wire logic              clk_en,
	// AHB-Lite slave
	input  wire logic              hsel,
	input  wire logic [31:0]       haddr,
	input  wire logic [1:0]        htrans,
	input  wire logic              hwrite,
	input  wire logic [2:0]        hsize,
	input  wire logic [31:0]       hwdata,
	input  wire logic              hready,
	output logic                   hreadyout,
	output logic [31:0]            hrdata,
	output logic                   hresp,
	// External pins and comparators
	input  wire logic              port3_bit1_pin,
	input  wire logic              port3_bit2_pin,
	input  wire logic              port3_bit3_pin,
	input  wire logic              comparator_one_event,
	input  wire logic              comparator_two_event,
	// Internal request pulses
	input  wire logic              timer16_event,
	input  wire logic              timer8_event,
	input  wire logic              low_voltage_detector,
	// Core sequencer
	input  wire logic              core_ready,
	input  wire logic              core_reenable,
	input  wire vie_ctx_type       core_ctx,
	output logic                   int_cycle_busy,
	output logic                   ctx_save,
	output vie_ctx_type            saved_ctx,
	output logic                   branch_valid,
	output logic [15:0]            branch_addr,
	// Program memory
	output logic                   pmem_rd,
	output logic [ADDR_W-1:0]      pmem_addr,
	input  wire logic [7:0]        pmem_data
);

	typedef enum {
		ST_IDLE,
		ST_SAVE,
		ST_VEC_HI,
		ST_VEC_LO,
		ST_LAST,
		ST_BRANCH
	} vie_state_type;

	// Cyclic priority search starting at the line software names
	function automatic logic [3:0] pick(input logic [5:0] req, input logic [2:0] start);
		logic [3:0] res;
		int         j;
		res = 4'h0;
		for (int i = VIE_LINES - 1; i >= 0; i--)
		begin
			j = (int'(start) + i) % VIE_LINES;
			if (req[j])
				res = {1'b1, 3'(j)};
		end
		return res;
	endfunction

	// Edge hit for a line whose rising select is own; falling taken when own is clear or other is set
	function automatic logic edge_hit(input logic own, input logic other, input logic prev,
		input logic cur);
		return (own & cur & ~prev) | ((~own | other) & prev & ~cur);
	endfunction

	vie_state_type state;
	vie_irq_type   irq;
	logic [5:0]    mask;
	logic          global_en;
	logic [2:0]    prio_start;
	logic [4:0]    sync1;
	logic [4:0]    sync2;
	logic [2:0]    prev_src;
	logic [2:0]    served;
	logic          dph_valid;
	logic          dph_write;
	logic [9:0]    dph_idx;
	logic [7:0]    vec_hi;

	logic [2:0]    src;
	logic [5:0]    hw_set;
	logic [5:0]    serve_clr;
	logic [3:0]    winner;
	logic          take;
	logic          wr_irq;
	logic          wr_mask;
	logic          wr_prio;
	logic          addr_phase;

	// Pins and comparators cross into hclk through two flip-flops
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			sync1 <= 5'h00;
			sync2 <= 5'h00;
		end
		else if (clk_en)
		begin
			sync1 <= {comparator_two_event, comparator_one_event,
				port3_bit3_pin, port3_bit2_pin, port3_bit1_pin};
			sync2 <= sync1;
		end
	end

	// Line sources: 0 = pin 2 or comparator two, 1 = pin 3, 2 = pin 1 or comparator one
	always_comb
	begin
		src[VIE_LINE0] = sync2[1] | sync2[4];
		src[VIE_LINE1] = sync2[2];
		src[VIE_LINE2] = sync2[0] | sync2[3];
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			prev_src <= 3'h0;
		else if (clk_en)
			prev_src <= src;
	end

	always_comb
	begin
		hw_set[VIE_LINE0] = edge_hit(irq.edge_sel[0], irq.edge_sel[1],
			prev_src[VIE_LINE0], src[VIE_LINE0]);
		hw_set[VIE_LINE1] = prev_src[VIE_LINE1] & ~src[VIE_LINE1];
		hw_set[VIE_LINE2] = edge_hit(irq.edge_sel[1], irq.edge_sel[0],
			prev_src[VIE_LINE2], src[VIE_LINE2]);
		hw_set[VIE_LINE3] = timer16_event;
		hw_set[VIE_LINE4] = timer8_event;
		hw_set[VIE_LINE5] = low_voltage_detector;
	end

	// Bus: address phase taken when selected, active and the bus is ready
	assign addr_phase = hsel & htrans[VIE_HTRANS_ACTIVE] & hready & clk_en;
	// Stalls the bus while frozen so no data phase is lost
	assign hreadyout = clk_en;
	assign hresp = 1'b0;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			dph_valid <= 1'b0;
			dph_write <= 1'b0;
			dph_idx   <= 10'h000;
		end
		else if (clk_en)
		begin
			dph_valid <= addr_phase;
			dph_write <= addr_phase & hwrite;
			dph_idx   <= haddr[VIE_IDX_MSB:VIE_IDX_LSB];
		end
	end

	assign wr_irq  = dph_write & clk_en & (dph_idx == VIE_IDX_IRQ);
	assign wr_mask = dph_write & clk_en & (dph_idx == VIE_IDX_MASK);
	assign wr_prio = dph_write & clk_en & (dph_idx == VIE_IDX_PRIO);

	// Read mux of register flops, so a read right after a write sees the new value
	always_comb
	begin
		hrdata = 32'h0000_0000;
		if (dph_valid && !dph_write)
		begin
			case (dph_idx)
				VIE_IDX_IRQ:  hrdata[7:0] = irq;
				VIE_IDX_MASK: hrdata[7:0] = {global_en, 1'b0, mask};
				VIE_IDX_PRIO: hrdata[2:0] = prio_start;
				VIE_IDX_PINS: hrdata[2:0] = {sync2[0], sync2[2], sync2[1]};
				default:      hrdata = 32'h0000_0000;
			endcase
		end
	end

	// Edge code and pending bits share one process; pending records regardless of mask, a new edge beats any clear
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			irq.edge_sel <= VIE_EDGE_RST;
			irq.pending  <= VIE_PEND_RST;
		end
		else if (clk_en)
		begin
			if (wr_irq)
			begin
				irq.edge_sel <= hwdata[VIE_EDGE_LINE2:VIE_EDGE_LINE0];
				irq.pending  <= hwdata[VIE_LINES-1:0] & ~serve_clr | hw_set;
			end
			else
				irq.pending <= irq.pending & ~serve_clr | hw_set;
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			mask       <= VIE_MASK_RST;
			prio_start <= VIE_PRIO_RST;
		end
		else
		begin
			if (wr_mask)
				mask <= hwdata[VIE_LINES-1:0];
			if (wr_prio)
				prio_start <= hwdata[2:0];
		end
	end

	// Global enable: the machine cycle wins over a software set in the same cycle
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			global_en <= 1'b0;
		else if (clk_en)
		begin
			if (take)
				global_en <= 1'b0;
			else if (core_reenable)
				global_en <= 1'b1;
			else if (wr_mask)
				global_en <= hwdata[VIE_GLOBAL_EN];
		end
	end

	// Only unmasked requests compete; polled systems keep all masked
	assign winner = pick(irq.pending & mask, prio_start);
	assign take   = clk_en & (state == ST_IDLE) & global_en & core_ready & winner[3];

	always_comb
	begin
		serve_clr = 6'h00;
		if (take)
			serve_clr[winner[2:0]] = 1'b1;
	end

	// Interrupt machine cycle
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			state <= ST_IDLE;
		else if (clk_en)
		begin
			case (state)
				ST_IDLE:   state <= take ? ST_SAVE : ST_IDLE;
				ST_SAVE:   state <= ST_VEC_HI;
				ST_VEC_HI: state <= ST_VEC_LO;
				ST_VEC_LO: state <= ST_LAST;
				ST_LAST:   state <= ST_BRANCH;
				ST_BRANCH: state <= ST_IDLE;
				default:   state <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			served    <= 3'h0;
			saved_ctx <= '0;
		end
		else if (take)
		begin
			served    <= winner[2:0];
			saved_ctx <= core_ctx;
		end
	end

	// Vector fetch: entry n sits at 2n (upper byte) and 2n+1 (lower byte)
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			pmem_addr <= '0;
		else if (clk_en)
		begin
			if (state == ST_SAVE)
				pmem_addr <= ADDR_W'(int'(served) * VIE_VEC_STRIDE);
			else if (state == ST_VEC_HI)
				pmem_addr <= pmem_addr + ADDR_W'(1);
		end
	end

	// Memory answers one cycle after each read strobe
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			vec_hi      <= 8'h00;
			branch_addr <= 16'h0000;
		end
		else if (clk_en)
		begin
			if (state == ST_VEC_LO)
				vec_hi <= pmem_data;
			if (state == ST_LAST)
				branch_addr <= {vec_hi, pmem_data};
		end
	end

	assign pmem_rd        = clk_en & ((state == ST_VEC_HI) | (state == ST_VEC_LO));
	assign ctx_save       = clk_en & (state == ST_SAVE);
	assign branch_valid   = clk_en & (state == ST_BRANCH);
	assign int_cycle_busy = (state != ST_IDLE);

endmodule // vie_ctrl
`default_nettype wire

// >>> vie_pkg.sv
// Constants, register map and carrier types of the vectored interrupt block
package vie_pkg;
	// Word index of each register; byte address is four times the index
	localparam logic [9:0] VIE_IDX_PRIO = 10'h0F9;
	localparam logic [9:0] VIE_IDX_IRQ  = 10'h0FA;
	localparam logic [9:0] VIE_IDX_MASK = 10'h0FB;
	localparam logic [9:0] VIE_IDX_PINS = 10'h0FC;
	localparam int VIE_IDX_LSB = 2;
	localparam int VIE_IDX_MSB = 11;

	// Field positions
	localparam int VIE_EDGE_LINE2 = 7;
	localparam int VIE_EDGE_LINE0 = 6;
	localparam int VIE_GLOBAL_EN  = 7;
	localparam int VIE_LINES      = 6;

	// Reset values
	localparam logic [1:0] VIE_EDGE_RST = 2'h0;
	localparam logic [5:0] VIE_PEND_RST = 6'h00;
	localparam logic [5:0] VIE_MASK_RST = 6'h00;
	localparam logic [2:0] VIE_PRIO_RST = 3'h0;

	// Program-memory vector entries are two bytes apart
	localparam int VIE_VEC_STRIDE = 2;

	// Request line numbers
	localparam int VIE_LINE0 = 0;
	localparam int VIE_LINE1 = 1;
	localparam int VIE_LINE2 = 2;
	localparam int VIE_LINE3 = 3;
	localparam int VIE_LINE4 = 4;
	localparam int VIE_LINE5 = 5;

	// AHB-Lite transfer type bit that marks NONSEQ or SEQ
	localparam int VIE_HTRANS_ACTIVE = 1;

	// Context handed over by the core and saved by the machine cycle
	typedef struct packed {
		logic [15:0] pc;
		logic [7:0]  flags;
	} vie_ctx_type;

	// Request register layout
	typedef struct packed {
		logic [1:0] edge_sel;
		logic [5:0] pending;
	} vie_irq_type;
endpackage

// >>> vie_ctrl_asserts.sv
// Port checker of the vectored interrupt block
`timescale 1ns/100ps
`default_nettype none
module vie_ctrl_asserts
	import vie_pkg::*;
#(
	parameter int ADDR_W = 16
)(
	// Clock and reset
	input wire logic              hclk,
	input wire logic              hresetn,
	// Bus
	input wire logic              clk_en,
	input wire logic              hreadyout,
	input wire logic              hresp,
	// Core sequencer
	input wire vie_ctx_type       core_ctx,
	input wire logic              ctx_save,
	input wire vie_ctx_type       saved_ctx,
	input wire logic              int_cycle_busy,
	input wire logic              branch_valid,
	input wire logic [15:0]       branch_addr,
	// Program memory
	input wire logic              pmem_rd,
	input wire logic [ADDR_W-1:0] pmem_addr,
	input wire logic [7:0]        pmem_data
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	bus_okay_a: assert property (!hresp && hreadyout == clk_en)
		else $error("bus answer wrong");
	ctx_capture_a: assert property (ctx_save |-> saved_ctx == $past(core_ctx))
		else $error("context not saved");
	busy_span_a: assert property (ctx_save |-> int_cycle_busy [*4])
		else $error("busy dropped early");
	no_retake_a: assert property (ctx_save |=> !ctx_save [*5])
		else $error("cycle taken again");
	fetch_pair_a: assert property (ctx_save |=> pmem_rd ##1 pmem_rd ##1 !pmem_rd)
		else $error("vector fetch not two bytes");
	fetch_even_a: assert property ($rose(pmem_rd) |-> !pmem_addr[0])
		else $error("vector fetch odd start");
	fetch_addr_a: assert property (pmem_rd && $past(pmem_rd) |-> pmem_addr == $past(pmem_addr) + 1'b1)
		else $error("second byte address wrong");
	branch_time_a: assert property (ctx_save |-> ##4 branch_valid)
		else $error("branch late");
	vector_join_a: assert property (branch_valid |-> branch_addr == {$past(pmem_data, 2), $past(pmem_data)})
		else $error("vector bytes wrong");
	cover property (ctx_save);
	cover property (branch_valid);
	cover property ($rose(pmem_rd));
endmodule // vie_ctrl_asserts
bind vie_ctrl vie_ctrl_asserts #(.ADDR_W(ADDR_W)) chk_u (
	.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hreadyout(hreadyout), .hresp(hresp),
	.core_ctx(core_ctx), .ctx_save(ctx_save), .saved_ctx(saved_ctx), .int_cycle_busy(int_cycle_busy),
	.branch_valid(branch_valid), .branch_addr(branch_addr), .pmem_rd(pmem_rd), .pmem_addr(pmem_addr),
	.pmem_data(pmem_data)
);
`default_nettype wire

// >>> vie_pmem_model.sv
// Program memory model answering vector fetches
`timescale 1ns/100ps
`default_nettype none
module vie_pmem_model (
	// Clock
	input wire logic        hclk,
	// Fetch port
	input wire logic        pmem_rd,
	input wire logic [15:0] pmem_addr,
	output logic [7:0]      pmem_data
);
	initial pmem_data = 8'h00;
	// Outside a fetch the byte flips each cycle, so a late sample cannot pass
	always @(posedge hclk)
		pmem_data <= pmem_rd ? (pmem_addr[7:0] ^ 8'h5A) : ~pmem_data;
endmodule // vie_pmem_model
`default_nettype wire

// >>> tb_top.sv
// Testbench of the vectored interrupt block
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin errors++; \
	$display("wrong value at %0t: got %h want %h", $time, a, e); end end
module tb_top
	import vie_pkg::*;
;
	localparam logic [31:0] A_PRIO = 32'(VIE_IDX_PRIO) << 2;
	localparam logic [31:0] A_REQ  = 32'(VIE_IDX_IRQ) << 2;
	localparam logic [31:0] A_MASK = 32'(VIE_IDX_MASK) << 2;
	localparam logic [31:0] A_PINS = 32'(VIE_IDX_PINS) << 2;
	int errors, total_checks, cyc;
	logic hclk, hresetn, clk_en, hsel, hwrite, core_ready, core_reenable;
	logic port3_bit1_pin, port3_bit2_pin, port3_bit3_pin, comparator_one_event, comparator_two_event;
	logic timer16_event, timer8_event, low_voltage_detector;
	logic hready, hreadyout, hresp, int_cycle_busy, ctx_save, branch_valid, pmem_rd;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [7:0]  pmem_data;
	logic [15:0] branch_addr, pmem_addr;
	logic [31:0] haddr, hwdata, hrdata;
	vie_ctx_type core_ctx, saved_ctx;
	assign hready = hreadyout;
	vie_ctrl dut_u (
		.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
		.port3_bit1_pin(port3_bit1_pin), .port3_bit2_pin(port3_bit2_pin), .port3_bit3_pin(port3_bit3_pin),
		.comparator_one_event(comparator_one_event), .comparator_two_event(comparator_two_event),
		.timer16_event(timer16_event), .timer8_event(timer8_event), .low_voltage_detector(low_voltage_detector),
		.core_ready(core_ready), .core_reenable(core_reenable), .core_ctx(core_ctx),
		.int_cycle_busy(int_cycle_busy), .ctx_save(ctx_save), .saved_ctx(saved_ctx),
		.branch_valid(branch_valid), .branch_addr(branch_addr),
		.pmem_rd(pmem_rd), .pmem_addr(pmem_addr), .pmem_data(pmem_data)
	);
	vie_pmem_model mem_u (
		.hclk(hclk), .pmem_rd(pmem_rd), .pmem_addr(pmem_addr), .pmem_data(pmem_data)
	);
	always #2 hclk = ~hclk;
	always @(posedge hclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			errors++;
			close_out;
		end
	end
	function automatic logic [15:0] vec(input int n);
		return {8'(2 * n) ^ 8'h5A, 8'(2 * n + 1) ^ 8'h5A};
	endfunction
	task automatic close_out;
		if (errors == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge hclk);
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask
	task automatic rd_chk(input logic [31:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		`CHK(q, e)
	endtask
	task automatic s_reset;
		// A write while the slave is not selected must leave the register alone
		hsel <= 1'b0;
		wr(A_PRIO, 32'h7);
		hsel <= 1'b1;
		wr(32'h100, 32'hFF);
		rd_chk(32'h100, 32'h0);
		rd_chk(A_REQ, 32'h0);
		rd_chk(A_MASK, 32'h0);
		rd_chk(A_PRIO, 32'h0);
	endtask
	task automatic s_edges;
		logic [1:0] c;
		for (int i = 0; i < 4; i++)
		begin
			c = 2'(i);
			wr(A_REQ, {24'h0, c, 6'h0});
			port3_bit1_pin <= 1'b1;
			port3_bit2_pin <= 1'b1;
			repeat (5) @(posedge hclk);
			rd_chk(A_PINS, 32'h5);
			rd_chk(A_REQ, {24'h0, c, 3'h0, c[1], 1'b0, c[0]});
			wr(A_REQ, {24'h0, c, 6'h0});
			port3_bit1_pin <= 1'b0;
			port3_bit2_pin <= 1'b0;
			repeat (5) @(posedge hclk);
			rd_chk(A_REQ, {24'h0, c, 3'h0, ~c[1] | c[0], 1'b0, ~c[0] | c[1]});
		end
	endtask
	task automatic s_sources;
		wr(A_REQ, 32'hC0);
		port3_bit3_pin <= 1'b1;
		repeat (5) @(posedge hclk);
		rd_chk(A_PINS, 32'h2);
		rd_chk(A_REQ, 32'hC0);
		comparator_one_event <= 1'b1;
		comparator_two_event <= 1'b1;
		port3_bit3_pin <= 1'b0;
		{timer16_event, timer8_event, low_voltage_detector} <= 3'h7;
		@(posedge hclk);
		{timer16_event, timer8_event, low_voltage_detector} <= 3'h0;
		repeat (5) @(posedge hclk);
		rd_chk(A_REQ, 32'hFF);
	endtask
	task automatic s_serve;
		int n;
		wr(A_PRIO, 32'h3);
		wr(A_MASK, 32'hBF);
		for (int i = 0; i < 6; i++)
		begin
			core_ctx <= {16'h1200 + 16'(i), 8'(i)};
			core_ready <= 1'b1;
			n = 0;
			do
			begin
				@(posedge hclk);
				n++;
			end
			while (branch_valid !== 1'b1 && n < 40);
			`CHK(branch_addr, vec((3 + i) % 6))
			`CHK(saved_ctx, {16'h1200 + 16'(i), 8'(i)})
			if (i == 0)
				rd_chk(A_MASK, 32'h3F);
			@(posedge hclk);
			core_reenable <= 1'b1;
			@(posedge hclk);
			core_reenable <= 1'b0;
		end
		rd_chk(A_REQ, 32'hC0);
	endtask
	// All lines masked with interrupts enabled: the request is recorded, never served
	task automatic s_polled;
		wr(A_MASK, 32'h80);
		core_ctx <= 24'hABCDEF;
		timer16_event <= 1'b1;
		@(posedge hclk);
		timer16_event <= 1'b0;
		repeat (8) @(posedge hclk);
		`CHK(saved_ctx, {16'h1205, 8'h05})
		rd_chk(A_REQ, 32'hC8);
	endtask
	// A write issued while the block is frozen waits for the enable, then lands
	task automatic s_freeze;
		clk_en <= 1'b0;
		fork
			wr(A_PRIO, 32'h5);
			begin
				repeat (4) @(posedge hclk);
				clk_en <= 1'b1;
			end
		join
		rd_chk(A_PRIO, 32'h5);
	endtask
	initial
	begin
		{errors, total_checks, cyc} = '0;
		{hclk, hresetn, hwrite, core_ready, core_reenable} = 5'h0;
		{clk_en, hsel, hsize, htrans, haddr, hwdata, core_ctx} = {2'h3, 3'h2, 2'h0, 64'h0, 24'h0};
		{port3_bit1_pin, port3_bit2_pin, port3_bit3_pin, comparator_one_event, comparator_two_event} = 5'h0;
		{timer16_event, timer8_event, low_voltage_detector} = 3'h0;
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		s_reset;
		s_edges;
		s_sources;
		s_serve;
		s_polled;
		s_freeze;
		close_out;
	end
endmodule // tb_top
`default_nettype wire
